/* File: verilog/parallel_to_lvds_display_serializer.sv */
// Display link transmitter: parallel pixel words in, four serial lanes plus clock out.
// Assumes clk is the parallel input clock and linkBitClk the serial bit clock from the
// transmit clock generator; the differential pads resolve P/N and enable.
`timescale 1ns/1ns
`default_nettype none
module parallel_to_lvds_display_serializer
   import lvds_link_pkg::*;
#(
   parameter int LOCK_COUNT = LOCK_CYCLES
) (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                linkBitClk,
   input  wire logic                powerDownN,
   input  wire logic [COLOUR_W-1:0] parallelDataInputs,
   input  wire logic                lineSync,
   input  wire logic                frameSync,
   input  wire logic                pixelValidFlag,
   input  wire logic                spareBit,
   output logic      [LANES-1:0]    laneP_r,
   output logic      [LANES-1:0]    laneN_r,
   output logic                     forwardedLinkClockP_r,
   output logic                     forwardedLinkClockN_r,
   output logic                     driveEnable_r,
   output logic                     wordOverrun_r
);
   typedef enum logic [1:0] {LINK_OFF, LINK_LOW, LINK_RUN} linkState_t;

   // ---- Parallel clock domain ----
   logic [WORD_W-1:0] capWord_r;
   logic              pdMetaClk_r;
   logic              pdSyncClk_r;
   logic [16:0]       lockCnt_r;
   logic              locked_r;
   logic              heartbeat_r;
   wire               bufInReady;
   wire  [WORD_W-1:0] inWord;
   wire               lockDone;

   assign inWord   = {spareBit, pixelValidFlag, frameSync, lineSync, parallelDataInputs};
   assign lockDone = (lockCnt_r == 17'(LOCK_COUNT));

   // Capture on the falling edge; no period check, so a swept clock is simply followed
   always_ff @(negedge clk or posedge reset) begin
      if (reset) begin
         capWord_r <= '0;
      end else begin
         capWord_r <= inWord;
      end
   end

   // Power-down crossing and lock timer; any arrival order settles through here
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pdMetaClk_r <= 1'b0;
         pdSyncClk_r <= 1'b0;
         lockCnt_r   <= '0;
         locked_r    <= 1'b0;
         heartbeat_r <= 1'b0;
      end else begin
         pdMetaClk_r <= powerDownN;
         pdSyncClk_r <= pdMetaClk_r;
         heartbeat_r <= !heartbeat_r;
         if (!pdSyncClk_r) begin
            lockCnt_r <= '0;
            locked_r  <= 1'b0;
         end else if (!lockDone) begin
            lockCnt_r <= lockCnt_r + 17'h00001;
         end else begin
            locked_r  <= 1'b1;
         end
      end
   end

   // The link cannot stall the panel, so a refused word is flagged until power-down
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wordOverrun_r <= 1'b0;
      end else if (!pdSyncClk_r) begin
         wordOverrun_r <= 1'b0;
      end else if (locked_r && !bufInReady) begin
         wordOverrun_r <= 1'b1;
      end
   end

   // ---- Link clock domain ----
   wire               bufOutValid;
   wire  [WORD_W-1:0] bufOutData;
   logic              pdMetaLink_r;
   logic              pdLink_r;
   logic              lockMeta_r;
   logic              lockLink_r;
   logic              beatMeta_r;
   logic              beatSync_r;
   logic              beatSeen_r;
   logic [MISS_W-1:0] missCnt_r;
   logic              clockMissing_r;
   logic [SLOT_W-1:0] slot_r;
   logic [WORD_W-1:0] txWord_r;
   linkState_t        state_r;
   linkState_t        state_nxt;
   wire               running;
   wire               loadSlot;
   wire               popWord;
   wire  [WORD_W-1:0] curWord;
   wire  [LANES-1:0]  laneBits;
   wire  [SLOT_W-1:0] slot_nxt;

   word_handoff_buffer #(
      .WIDTH  (WORD_W),
      .ADDR_W (BUF_ADDR_W)
   ) u_buffer (
      .wrClk    (clk),
      .rdClk    (linkBitClk),
      .reset    (reset),
      .inValid  (locked_r),
      .inReady  (bufInReady),
      .inData   (capWord_r),
      .outValid (bufOutValid),
      .outReady (popWord),
      .outData  (bufOutData)
   );

   // Link state: off while powered down, low while the source is silent or unlocked
   assign state_nxt = !pdLink_r                      ? LINK_OFF :
                      (clockMissing_r || !lockLink_r) ? LINK_LOW :
                                                        LINK_RUN;
   assign running  = (state_r == LINK_RUN);
   assign loadSlot = (slot_r == '0);
   assign popWord  = running && loadSlot && bufOutValid;
   assign curWord  = popWord ? bufOutData : txWord_r; // An empty buffer repeats the last word
   assign slot_nxt = (slot_r == SLOT_LAST) ? '0 : slot_r + 3'h1;

   // Lane n carries word bits n*7 .. n*7+6, slot s sends bit s
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         assign laneBits[g] = curWord[g * SLOTS + int'(slot_r)];
      end
   endgenerate

   // Crossings into the link domain; the third heartbeat flop feeds the edge compare
   always_ff @(posedge linkBitClk or posedge reset) begin
      if (reset) begin
         pdMetaLink_r <= 1'b0;
         pdLink_r     <= 1'b0;
         lockMeta_r   <= 1'b0;
         lockLink_r   <= 1'b0;
         beatMeta_r   <= 1'b0;
         beatSync_r   <= 1'b0;
         beatSeen_r   <= 1'b0;
      end else begin
         pdMetaLink_r <= powerDownN;
         pdLink_r     <= pdMetaLink_r;
         lockMeta_r   <= locked_r;
         lockLink_r   <= lockMeta_r;
         beatMeta_r   <= heartbeat_r;
         beatSync_r   <= beatMeta_r;
         beatSeen_r   <= beatSync_r;
      end
   end

   // Missing-clock watchdog counted in bit clocks
   always_ff @(posedge linkBitClk or posedge reset) begin
      if (reset) begin
         missCnt_r      <= '0;
         clockMissing_r <= 1'b1;
      end else if (beatSync_r != beatSeen_r) begin
         missCnt_r      <= '0;
         clockMissing_r <= 1'b0;
      end else if (missCnt_r == MISS_W'(MISS_CYCLES)) begin
         clockMissing_r <= 1'b1;
      end else begin
         missCnt_r      <= missCnt_r + 8'h01;
      end
   end

   // Slot sequencer and word holder
   always_ff @(posedge linkBitClk or posedge reset) begin
      if (reset) begin
         state_r  <= LINK_OFF;
         slot_r   <= '0;
         txWord_r <= '0;
      end else begin
         state_r  <= state_nxt;
         slot_r   <= running ? slot_nxt : '0;
         txWord_r <= curWord;
      end
   end

   // Pad drive: registered so the pads see no decode glitches
   always_ff @(posedge linkBitClk or posedge reset) begin
      if (reset) begin
         laneP_r               <= '0;
         laneN_r               <= '0;
         forwardedLinkClockP_r <= 1'b0;
         forwardedLinkClockN_r <= 1'b0;
         driveEnable_r         <= 1'b0;
      end else begin
         case (state_r)
            LINK_RUN: begin
               laneP_r               <= laneBits;
               laneN_r               <= ~laneBits;
               forwardedLinkClockP_r <= FWD_CLK_PATTERN[slot_r];
               forwardedLinkClockN_r <= !FWD_CLK_PATTERN[slot_r];
               driveEnable_r         <= pdLink_r;
            end
            LINK_LOW: begin
               laneP_r               <= '0;
               laneN_r               <= '1;
               forwardedLinkClockP_r <= 1'b0;
               forwardedLinkClockN_r <= 1'b1;
               driveEnable_r         <= pdLink_r;
            end
            default: begin
               laneP_r               <= '0;
               laneN_r               <= '0;
               forwardedLinkClockP_r <= 1'b0;
               forwardedLinkClockN_r <= 1'b0;
               driveEnable_r         <= 1'b0;
            end
         endcase
      end
   end

   // ---- Checks ----
   sequence pdHeldLow;
      !powerDownN [*4];
   endsequence

   sequence runTwo;
      (state_r == LINK_RUN) [*2];
   endsequence

   chk_pd_disable_delay: assert property (@(posedge linkBitClk) disable iff (reset)
      pdHeldLow |-> !driveEnable_r)
      else $error("drivers still enabled after power-down");

   chk_off_high_z: assert property (@(posedge linkBitClk) disable iff (reset)
      (state_r == LINK_OFF) |=> !driveEnable_r)
      else $error("drivers enabled while off");

   chk_missing_low: assert property (@(posedge linkBitClk) disable iff (reset)
      (clockMissing_r && pdLink_r) [*2] |=> (laneP_r == '0) && !forwardedLinkClockP_r)
      else $error("pairs not low with input clock missing");

   chk_slot_wrap: assert property (@(posedge linkBitClk) disable iff (reset)
      running && (slot_r == SLOT_LAST) |=> (slot_r == '0))
      else $error("slot did not wrap after six");

   chk_slot_step: assert property (@(posedge linkBitClk) disable iff (reset)
      running && (slot_r < SLOT_LAST) && (state_nxt == LINK_RUN)
      |=> (slot_r == $past(slot_r) + 3'h1))
      else $error("slot did not advance by one");

   chk_fwd_clock: assert property (@(posedge linkBitClk) disable iff (reset)
      runTwo |-> forwardedLinkClockP_r == FWD_CLK_PATTERN[$past(slot_r)])
      else $error("forwarded clock pattern wrong");

   chk_lane_word: assert property (@(posedge linkBitClk) disable iff (reset)
      runTwo |-> laneP_r[LANES-1] == $past(curWord[(LANES-1)*SLOTS + int'(slot_r)]))
      else $error("top lane bit does not match word");

   chk_lock_gate: assert property (@(posedge clk) disable iff (reset)
      $rose(locked_r) |-> lockDone && $past(pdSyncClk_r))
      else $error("lock before full lock count");

   chk_capture_word: assert property (@(negedge clk) disable iff (reset)
      1'b1 |=> capWord_r == $past(inWord))
      else $error("falling edge word not captured");

   chk_no_run_unlocked: assert property (@(posedge linkBitClk) disable iff (reset)
      !lockLink_r |=> (state_r != LINK_RUN))
      else $error("serial output running before lock");
endmodule
`default_nettype wire

/* File: verilog/lvds_link_pkg.sv */
// Constants shared by the display link transmitter and its handoff buffer.
// Assumes a parallel clock near 10 MHz and a faster bit clock on the link side.
package lvds_link_pkg;
   localparam int          WORD_W          = 28;       // Parallel word width
   localparam int          COLOUR_W        = 24;       // Colour bits in a word
   localparam int          LANES           = 4;        // Serial data lanes
   localparam int          SLOTS           = 7;        // Bit slots per lane per word
   localparam int          SLOT_W          = 3;        // Slot counter width
   localparam logic [2:0]  SLOT_LAST       = 3'h6;     // Highest slot number
   localparam logic [6:0]  FWD_CLK_PATTERN = 7'h63;    // Forwarded clock per slot, slot 0 high
   localparam int          CLK_PERIOD_NS   = 100;      // Parallel clock period
   localparam int          LINK_PERIOD_NS  = 15;       // Link bit clock period
   localparam int          LOCK_TIME_MS    = 10;       // Longest lock time
   localparam int          LOCK_CYCLES     = (LOCK_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int          PD_DELAY_NS     = 100;      // Longest output disable delay
   localparam int          PD_SYNC_CYCLES  = PD_DELAY_NS / LINK_PERIOD_NS;
   localparam int          MISS_PERIODS    = 3;        // Silent parallel periods before missing
   localparam int          MISS_CYCLES     =
      (MISS_PERIODS * CLK_PERIOD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   localparam int          MISS_W          = 8;        // Missing-clock counter width
   localparam int          BUF_ADDR_W      = 1;        // Two-entry buffer
endpackage

/* File: verilog/word_handoff_buffer.sv */
// Two-clock word buffer with gray-coded pointers, valid/ready on both sides.
// Assumes both resets are the same asynchronous reset; depth is 2**ADDR_W.
`timescale 1ns/1ns
`default_nettype none
module word_handoff_buffer #(
   parameter int WIDTH  = 28,
   parameter int ADDR_W = 1
) (
   input  wire logic             wrClk,
   input  wire logic             rdClk,
   input  wire logic             reset,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = ADDR_W + 1;

   function automatic logic [PW-1:0] toGray(input logic [PW-1:0] b);
      toGray = b ^ (b >> 1);
   endfunction

   function automatic logic [PW-1:0] fromGray(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b = '0;
      b[PW-1] = g[PW-1];
      // Walk down from the top bit so no index ever leaves the vector
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = g[i] ^ b[i+1];
      end
      fromGray = b;
   endfunction

   logic [WIDTH-1:0] mem [2**ADDR_W];
   logic [PW-1:0]    wrBin_r;
   logic [PW-1:0]    rdBin_r;
   logic [PW-1:0]    wrGray_r;
   logic [PW-1:0]    rdGray_r;
   logic [PW-1:0]    rdGrayMeta_r;
   logic [PW-1:0]    rdGraySync_r;
   logic [PW-1:0]    wrGrayMeta_r;
   logic [PW-1:0]    wrGraySync_r;
   wire  [PW-1:0]    rdBinSeen;
   wire              doWrite;
   wire              doRead;
   wire  [PW-1:0]    wrBin_nxt;
   wire  [PW-1:0]    rdBin_nxt;

   // Full means same slot, opposite wrap bit; judged on the synchronised read pointer
   assign rdBinSeen = fromGray(rdGraySync_r);
   assign inReady   = !((wrBin_r[ADDR_W] != rdBinSeen[ADDR_W]) &&
                        (wrBin_r[ADDR_W-1:0] == rdBinSeen[ADDR_W-1:0]));
   assign outValid  = (rdGray_r != wrGraySync_r);
   assign outData   = mem[rdBin_r[ADDR_W-1:0]];
   assign doWrite   = inValid && inReady;
   assign doRead    = outValid && outReady;
   assign wrBin_nxt = wrBin_r + PW'(1);
   assign rdBin_nxt = rdBin_r + PW'(1);

   // Write side: storage and pointer
   always_ff @(posedge wrClk) begin
      if (doWrite) begin
         mem[wrBin_r[ADDR_W-1:0]] <= inData;
      end
   end

   always_ff @(posedge wrClk or posedge reset) begin
      if (reset) begin
         wrBin_r      <= '0;
         wrGray_r     <= '0;
         rdGrayMeta_r <= '0;
         rdGraySync_r <= '0;
      end else begin
         rdGrayMeta_r <= rdGray_r;
         rdGraySync_r <= rdGrayMeta_r;
         if (doWrite) begin
            wrBin_r  <= wrBin_nxt;
            wrGray_r <= toGray(wrBin_nxt);
         end
      end
   end

   // Read side pointer; only gray values cross, so a torn sample is off by one at most
   always_ff @(posedge rdClk or posedge reset) begin
      if (reset) begin
         rdBin_r      <= '0;
         rdGray_r     <= '0;
         wrGrayMeta_r <= '0;
         wrGraySync_r <= '0;
      end else begin
         wrGrayMeta_r <= wrGray_r;
         wrGraySync_r <= wrGrayMeta_r;
         if (doRead) begin
            rdBin_r  <= rdBin_nxt;
            rdGray_r <= toGray(rdBin_nxt);
         end
      end
   end
endmodule
`default_nettype wire

/* File: test/lvds_panel_receiver.sv */
// Panel-side receiver model: rebuilds words from the four lanes and the forwarded clock.
// Assumes pair outputs that change just after each linkBitClk rising edge.
`timescale 1ns/1ns
`default_nettype none
module lvds_panel_receiver
   import lvds_link_pkg::*;
(
   input  wire logic        linkBitClk,
   input  wire logic [3:0]  laneP,
   input  wire logic [3:0]  laneN,
   input  wire logic        fwdP,
   input  wire logic        fwdN,
   input  wire logic        driveEnable,
   output logic      [27:0] rxWord,
   output int               rxCount,
   output int               errCount
);
   logic [6:0]  clkHist;
   logic [6:0]  laneHist [4];
   int          gap;
   logic        synced;

   initial begin
      rxWord = 28'h0000000;
      rxCount = 0;
      errCount = 0;
      clkHist = 7'h00;
      gap = 0;
      synced = 1'b0;
      for (int n = 0; n < 4; n++) begin
         laneHist[n] = 7'h00;
      end
   end

   // Slot s lands in bit s of each history; the whole clock shape marks the end of slot 6.
   // Its rising edge is not at slot 0, so framing keys on the full shape, not on an edge.
   always @(posedge linkBitClk) begin
      if (driveEnable) begin
         if (laneN !== ~laneP || fwdN !== ~fwdP) begin
            errCount++;
         end
         clkHist = {fwdP, clkHist[6:1]};
         for (int n = 0; n < 4; n++) begin
            laneHist[n] = {laneP[n], laneHist[n][6:1]};
         end
         gap++;
         if (clkHist == FWD_CLK_PATTERN) begin
            if (synced && gap != 7) begin
               errCount++;
            end
            rxWord = {laneHist[3], laneHist[2], laneHist[1], laneHist[0]};
            rxCount++;
            synced = 1'b1;
            gap = 0;
         end else if (clkHist == 7'h00) begin
            synced = 1'b0; // Idle low run: the next frame starts afresh
         end
      end else begin
         clkHist = 7'h00;
         synced = 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the display link transmitter with a panel receiver model.
// Assumes lock after LOCK_COUNT parallel cycles and a free-running 15 ns link clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        clk = 1'b0;
   logic        linkBitClk = 1'b0;
   logic        reset = 1'b1;
   logic        powerDownN = 1'b0;
   logic        clkRun = 1'b1;
   logic        seqMode = 1'b0;
   logic [27:0] txWord = 28'h5A3C96E;
   logic [3:0]  laneP;
   logic [3:0]  laneN;
   logic        fwdP;
   logic        fwdN;
   logic        driveEnable;
   logic        overrun;
   logic [10:0] pads;
   logic [27:0] rxWord;
   int          rxCount;
   int          errCount;
   int          badCount = 0;
   int          compares = 0;
   int          cycles = 0;
   int          holdCnt = 0;
   logic [27:0] pats [5] = '{28'h8000000, 28'h4000000, 28'h2000000, 28'h1000000, 28'h0A5C3E1};

   // Parallel clock at 50 percent duty; clkRun lets a test take it away.
   // It runs at 10 MHz, below the panel range; the overrun flag and the missing-clock watchdog depend on the rate.
   always #50 clk = clkRun ? ~clk : clk;
   // Link bit clock, phase unrelated to the parallel clock
   always begin
      #7 linkBitClk = 1'b1;
      #8 linkBitClk = 1'b0;
   end
   // Counting words, each held six cycles: the 105 ns link frame and the two-entry
   // buffer cannot carry one word per 100 ns, but no held value may go missing
   always @(negedge clk) begin
      if (seqMode) begin
         holdCnt <= (holdCnt == 5) ? 0 : holdCnt + 1;
         if (holdCnt == 5) begin
            txWord <= txWord + 28'h1;
         end
      end
   end
   assign pads = {driveEnable, fwdP, fwdN, laneP, laneN};

   parallel_to_lvds_display_serializer #(.LOCK_COUNT(20)) u_dut (
      .clk(clk), .reset(reset), .linkBitClk(linkBitClk), .powerDownN(powerDownN),
      .parallelDataInputs(txWord[23:0]), .lineSync(txWord[24]), .frameSync(txWord[25]),
      .pixelValidFlag(txWord[26]), .spareBit(txWord[27]),
      .laneP_r(laneP), .laneN_r(laneN), .forwardedLinkClockP_r(fwdP),
      .forwardedLinkClockN_r(fwdN), .driveEnable_r(driveEnable), .wordOverrun_r(overrun));

   lvds_panel_receiver u_rx (
      .linkBitClk(linkBitClk), .laneP(laneP), .laneN(laneN), .fwdP(fwdP), .fwdN(fwdN),
      .driveEnable(driveEnable), .rxWord(rxWord), .rxCount(rxCount), .errCount(errCount));

   task automatic check(input logic [27:0] seen, input logic [27:0] exp);
      compares++;
      if (seen !== exp) begin
         badCount++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finalReport;
      $display("Comparisons %0d, mismatches %0d", compares, badCount);
      if (badCount == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic waitClk(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Data was present before power-up; pairs idle low until lock, then each new
   // word seen at the far end is exactly the next count
   task automatic testLock;
      logic [27:0] prev;
      waitClk(4);
      powerDownN <= 1'b1;
      waitClk(8);
      check(28'(pads), 28'h50F);
      check(28'(rxCount), 28'h0);
      seqMode = 1'b1;
      repeat (2) @(rxCount);
      for (int i = 0; i < 6; i++) begin
         prev = rxWord;
         wait (rxWord != prev);
         check(rxWord, prev + 28'h1);
      end
      seqMode = 1'b0;
      $display("test lock done");
   endtask

   // One control bit at a time, then a colour pattern, shows where each part of the word lands
   task automatic testPatterns;
      waitClk(1);
      for (int i = 0; i < 5; i++) begin
         txWord <= pats[i];
         waitClk(12);
         check(rxWord, pats[i]);
      end
      waitClk(20);
      check(28'(overrun), 28'h1);
      $display("test patterns done");
   endtask

   // Drivers float within 100 ns; the overrun flag clears; lock returns on release
   task automatic testPowerDown;
      powerDownN <= 1'b0;
      #99;
      check(28'(pads), 28'h0);
      waitClk(12);
      check(28'(overrun), 28'h0);
      powerDownN <= 1'b1;
      txWord <= 28'h3C5A0F1;
      waitClk(40);
      check(rxWord, 28'h3C5A0F1);
      $display("test power down done");
   endtask

   // Clock stopped low while powered: every pair driven to logic low
   task automatic testMissingClock;
      @(negedge clk);
      clkRun = 1'b0;
      #1000;
      check(28'(pads), 28'h50F);
      clkRun = 1'b1;
      $display("test missing clock done");
   endtask

   // Hang guard on the free link clock, since the parallel clock may be stopped
   always @(posedge linkBitClk) begin
      cycles++;
      if (cycles == 8000) begin
         badCount++;
         finalReport;
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      reset <= 1'b0;
      testLock;
      testPatterns;
      testPowerDown;
      testMissingClock;
      check(28'(errCount), 28'h0);
      finalReport;
   end
endmodule
`default_nettype wire
